/* File: rtl/pmrs_pkg.sv */
// Purpose: shared constants and types of the perf monitor register bank
// Assumes: 32-bit AHB-Lite register port, byte addresses below 4 KB
// Notes: one word per register, reserved bits read as zero
package pmrs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_CNT = 4;
  localparam int NUM_SLV = 5;
  localparam int NUM_MST = 3;
  localparam int EV_W = 256;
  localparam int SEL_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_OVF = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CYC = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_SECACC = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_IMPERR = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_CTLOVR = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_SNPCTL = 12'h01C;
  // counter n lives at OFF_CNT_BASE + n*0x10: select, count, control
  localparam logic [ADDR_W-1:0] OFF_CNT_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] OFF_CNT_END = 12'h140;
  localparam logic [3:0] SUB_SEL = 4'h0;
  localparam logic [3:0] SUB_CNT = 4'h4;
  localparam logic [3:0] SUB_CTL = 4'h8;
  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_EVRST = 1;
  localparam int CTRL_CYCRST = 2;
  localparam int OVF_CYC = 4;
  localparam int CNT_EN = 0;
  localparam int SECACC_OPEN = 0;
  localparam int SNP_MAINT = 0;
  localparam int IMP_MST_LO = 8;
  localparam int IMP_W = 11;
  localparam int PROT_NS = 1;
  localparam logic [DATA_W-1:0] CNT_MAX = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] CNT_ONE = 32'h00000001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    PMRS_IDLE = 2'b00,
    PMRS_WRITE = 2'b01,
    PMRS_READ = 2'b10
  } pmrs_phase_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic secure;
    logic denied;
  } pmrs_req_s;
endpackage

/* File: rtl/pmrs_perf_monitor.sv */
// Purpose: perf monitor counters, secure register filter, error reporting
// Assumes: single clock mclk, synchronous active-low reset, zero-wait AHB
// Notes: denied accesses show DECERR on accessResp, AHB hresp stays OKAY
`timescale 1ns/1ps

// How it works
// - four event counters plus one cycle counter
// - select holds source [7:5], code [4:0]
// - slave code 03 reads, 0A snoop hits
// - counter control bit 0 enables that counter
// - control bits 2:1 clear all counters
// - control bit 0 globally starts or holds
// - cycle counter adds one per enabled cycle
// - readable overflow flag for every counter
// - nonsecure read of secure register: zero, DECERR
// - nonsecure write to secure register ignored, DECERR
// - only monitor registers open to nonsecure by default
// - secure access bit opens all but two
// - protection bit 1 low means secure
// - secure events counted only with debug enable
// - debug enable ignores privilege level
// - imprecise errors raise irq, record interface
// - precise errors never reach the irq path
// - snoop and DVM errors flagged by slave
// - speculative and internal write errors by master
// - split WriteUnique errors flagged by slave
// - maintenance snooped per control, forwarded on enable
// - events are one-cycle pulses on vector
module pmrs_perf_monitor
  import pmrs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [pmrs_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [3:0] hprot,
  input wire logic [pmrs_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [pmrs_pkg::DATA_W-1:0] hrdata,
  output logic [1:0] accessResp,
  input wire logic [pmrs_pkg::EV_W-1:0] event_pulse_vector,
  input wire logic [pmrs_pkg::EV_W-1:0] eventSecure,
  input wire logic secure_debug_enable,
  input wire logic [pmrs_pkg::NUM_SLV-1:0] slvImpErr,
  input wire logic [pmrs_pkg::NUM_MST-1:0] mstImpErr,
  output logic error_irq_n,
  input wire logic maintReq,
  input wire logic broadcast_maint_en,
  output logic maintSnoop,
  output logic maintForward
);
  import pmrs_pkg::*;

  function automatic logic isCntReg(input logic [ADDR_W-1:0] a);
    return (a >= OFF_CNT_BASE) && (a < OFF_CNT_END);
  endfunction

  function automatic logic [1:0] cntIdx(input logic [ADDR_W-1:0] a);
    return a[5:4];
  endfunction

  pmrs_phase_e phase;
  pmrs_req_s req;
  logic ctrlEn;
  logic secOpen;
  logic ctlOvr;
  logic snpCtl;
  logic [DATA_W-1:0] cycCnt;
  logic [NUM_CNT:0] ovf;
  logic [IMP_W-1:0] impErr;
  logic [DATA_W-1:0] cnt [NUM_CNT];
  logic [SEL_W-1:0] evSel [NUM_CNT];
  logic [NUM_CNT-1:0] cntEn;
  logic [NUM_CNT-1:0] cntInc;
  logic [NUM_CNT:0] ovfSet;
  logic [DATA_W-1:0] rdMux;
  logic [IMP_W-1:0] next_impErr;

  wire accept = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire isSecure = ~hprot[PROT_NS];
  wire isMon = isCntReg(haddr) || haddr == OFF_CTRL ||
    haddr == OFF_OVF || haddr == OFF_CYC;
  wire neverOpen = haddr == OFF_SECACC || haddr == OFF_CTLOVR;
  wire denyNow = !isSecure && !isMon &&
    (neverOpen || !secOpen);
  wire wrEn = (phase == PMRS_WRITE) && !req.denied;
  wire [3:0] sub = req.addr[3:0];
  wire wrCnt = wrEn && isCntReg(req.addr);
  wire wrCtrl = wrEn && req.addr == OFF_CTRL;
  wire evRst = wrCtrl && hwdata[CTRL_EVRST];
  wire cycRst = wrCtrl && hwdata[CTRL_CYCRST];
  wire wrCyc = wrEn && req.addr == OFF_CYC;
  wire wrOvf = wrEn && req.addr == OFF_OVF;
  wire wrImp = wrEn && req.addr == OFF_IMPERR;
  wire cycInc = ctrlEn;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ovfSet[NUM_CNT] = cycInc && cycCnt == CNT_MAX;

  // bus data phase tracking; read data registered at the accept edge,
  // safe because the master idles during each data phase
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase <= PMRS_IDLE;
      req <= '0;
      hrdata <= '0;
      accessResp <= RESP_OKAY;
    end else if (accept) begin
      phase <= hwrite ? PMRS_WRITE : PMRS_READ;
      req <= '{addr: haddr, secure: isSecure, denied: denyNow};
      hrdata <= (denyNow || hwrite) ? '0 : rdMux;
      accessResp <= denyNow ? RESP_DECERR : RESP_OKAY;
    end else begin
      phase <= PMRS_IDLE;
      accessResp <= RESP_OKAY;
    end
  end

  always_comb begin
    rdMux = '0;
    if (isCntReg(haddr)) begin
      case (haddr[3:0])
        SUB_SEL: rdMux[SEL_W-1:0] = evSel[cntIdx(haddr)];
        SUB_CNT: rdMux = cnt[cntIdx(haddr)];
        SUB_CTL: rdMux[CNT_EN] = cntEn[cntIdx(haddr)];
        default: rdMux = '0;
      endcase
    end else begin
      case (haddr)
        OFF_CTRL: rdMux[CTRL_EN] = ctrlEn;
        OFF_OVF: rdMux[NUM_CNT:0] = ovf;
        OFF_CYC: rdMux = cycCnt;
        OFF_SECACC: rdMux[SECACC_OPEN] = secOpen;
        OFF_IMPERR: rdMux[IMP_W-1:0] = impErr;
        OFF_CTLOVR: rdMux[0] = ctlOvr;
        OFF_SNPCTL: rdMux[SNP_MAINT] = snpCtl;
        default: rdMux = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrlEn <= 1'b0;
      secOpen <= 1'b0;
      ctlOvr <= 1'b0;
      snpCtl <= 1'b0;
    end else if (wrEn) begin
      if (req.addr == OFF_CTRL) ctrlEn <= hwdata[CTRL_EN];
      if (req.addr == OFF_SECACC) secOpen <= hwdata[SECACC_OPEN];
      if (req.addr == OFF_CTLOVR) ctlOvr <= hwdata[0];
      if (req.addr == OFF_SNPCTL) snpCtl <= hwdata[SNP_MAINT];
    end
  end

  // reset strobe beats both a software write and a same-cycle increment, a software write beats the increment
  always_ff @(posedge mclk) begin
    if (!rst_n) cycCnt <= '0;
    else if (cycRst) cycCnt <= '0;
    else if (wrCyc) cycCnt <= hwdata;
    else if (cycInc) cycCnt <= cycCnt + CNT_ONE;
  end

  // event counters; privilege is not an input here, so user and
  // privileged events are treated alike
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : gCnt
      wire mine = wrCnt && cntIdx(req.addr) == 2'(g);
      wire evHit = event_pulse_vector[evSel[g]] &&
        (!eventSecure[evSel[g]] || secure_debug_enable);
      assign cntInc[g] = ctrlEn && cntEn[g] && evHit;
      assign ovfSet[g] = cntInc[g] && cnt[g] == CNT_MAX;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          cnt[g] <= '0;
          evSel[g] <= '0;
          cntEn[g] <= 1'b0;
        end else begin
          if (evRst) cnt[g] <= '0;
          else if (mine && sub == SUB_CNT) cnt[g] <= hwdata;
          else if (cntInc[g]) cnt[g] <= cnt[g] + CNT_ONE;
          if (mine && sub == SUB_SEL) evSel[g] <= hwdata[SEL_W-1:0];
          if (mine && sub == SUB_CTL) cntEn[g] <= hwdata[CNT_EN];
        end
      end
    end
  endgenerate

  // write one to clear; a new overflow in the same cycle wins
  always_ff @(posedge mclk) begin
    if (!rst_n) ovf <= '0;
    else ovf <= (ovf & ~(wrOvf ? hwdata[NUM_CNT:0] : '0)) | ovfSet;
  end

  // only imprecise sources reach this register; precise errors answer
  // on their own transaction and are never wired here
  assign next_impErr = (impErr & ~(wrImp ? hwdata[IMP_W-1:0] : '0)) |
    {mstImpErr, 3'h0, slvImpErr};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      impErr <= '0;
      error_irq_n <= 1'b1;
    end else begin
      impErr <= next_impErr;
      error_irq_n <= ~|next_impErr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      maintSnoop <= 1'b0;
      maintForward <= 1'b0;
    end else begin
      maintSnoop <= maintReq && snpCtl;
      maintForward <= maintReq && broadcast_maint_en;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_denied_rd;
    accept && !hwrite && denyNow;
  endsequence
  sequence s_denied_wr;
    accept && hwrite && denyNow;
  endsequence

  property p_decerr_read;
    s_denied_rd |=> hrdata == '0 && accessResp == RESP_DECERR;
  endproperty
  a_decerr_read: assert property (p_decerr_read)
    else $error("denied read not zero with DECERR");

  property p_write_ignored;
    s_denied_wr |=> accessResp == RESP_DECERR ##1
      ($stable(secOpen) && $stable(ctlOvr) && $stable(snpCtl));
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("denied write changed state");

  property p_mon_open;
    accept && isMon |=> accessResp == RESP_OKAY;
  endproperty
  a_mon_open: assert property (p_mon_open)
    else $error("monitor register refused");

  property p_secacc_guard;
    accept && hprot[PROT_NS] && haddr == OFF_SECACC |=>
      accessResp == RESP_DECERR;
  endproperty
  a_secacc_guard: assert property (p_secacc_guard)
    else $error("nonsecure reached secure access register");

  property p_cycle_step;
    ctrlEn && !wrEn |=> cycCnt == $past(cycCnt) + CNT_ONE;
  endproperty
  a_cycle_step: assert property (p_cycle_step)
    else $error("cycle counter missed a step");

  property p_hold;
    (!ctrlEn && !wrEn) [*2] |-> $stable(cycCnt) && $stable(cnt[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counters moved while disabled");

  property p_wrap;
    cntInc[0] && cnt[0] == CNT_MAX && !wrEn |=> cnt[0] == '0 && ovf[0];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter 0 wrap did not flag overflow");

  property p_own_enable;
    !cntEn[1] && !wrEn |=> $stable(cnt[1]);
  endproperty
  a_own_enable: assert property (p_own_enable)
    else $error("disabled counter 1 moved");

  property p_clear;
    evRst && cycRst |=> cycCnt == '0 && cnt[2] == '0 && cnt[3] == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counters not cleared");

  property p_irq;
    (|slvImpErr || |mstImpErr) |=> !error_irq_n && impErr != '0;
  endproperty
  a_irq: assert property (p_irq)
    else $error("imprecise error did not raise irq");

  property p_maint;
    maintReq && !broadcast_maint_en |=> !maintForward;
  endproperty
  a_maint: assert property (p_maint)
    else $error("maintenance forwarded without enable");

  property p_maint_snoop;
    maintReq && snpCtl |=> maintSnoop;
  endproperty
  a_maint_snoop: assert property (p_maint_snoop)
    else $error("maintenance not snooped");

  property p_secure_filtered;
    !secure_debug_enable && eventSecure[evSel[0]] && !wrEn |=>
      $stable(cnt[0]);
  endproperty
  a_secure_filtered: assert property (p_secure_filtered)
    else $error("secure event counted without debug enable");

  property p_count_step;
    cntInc[0] && !wrEn |=> cnt[0] == $past(cnt[0]) + CNT_ONE;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter 0 missed an event");

  property p_ovf_sticky;
    ovf[NUM_CNT] && !wrEn |=> ovf[NUM_CNT];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("cycle overflow flag dropped");

  property p_precise_quiet;
    accept && denyNow && impErr == '0 && !(|slvImpErr) && !(|mstImpErr)
      |=> error_irq_n;
  endproperty
  a_precise_quiet: assert property (p_precise_quiet)
    else $error("precise error reached the irq");

  property p_secure_open;
    accept && !hprot[PROT_NS] |=> accessResp == RESP_OKAY;
  endproperty
  a_secure_open: assert property (p_secure_open)
    else $error("secure access refused");
endmodule

/* File: bench/pmrs_event_src.sv */
// Purpose: event source model on the far side of the perf monitor
// Assumes: bench raises go for one cycle per event
// Notes: secure vector marks only the bit that pulses
`timescale 1ns/1ps
module pmrs_event_src (
  input wire logic go,
  input wire logic [7:0] idx,
  input wire logic sec,
  output logic [pmrs_pkg::EV_W-1:0] pulses,
  output logic [pmrs_pkg::EV_W-1:0] secure
);
  import pmrs_pkg::*;
  wire logic [EV_W-1:0] oneHot = {{(EV_W-1){1'b0}}, 1'b1} << idx;
  // a pulse lasts exactly as long as go, one cycle per event
  assign pulses = go ? oneHot : {EV_W{1'b0}};
  assign secure = sec ? oneHot : {EV_W{1'b0}};
endmodule

/* File: bench/pmrs_perf_monitor_bench.sv */
// Purpose: self-checking bench of the perf monitor register bank
// Assumes: AHB-Lite slave, data and accessResp taken at data phase end
// Notes: hready is looped back from hreadyout
`timescale 1ns/1ps
module pmrs_perf_monitor_bench;
  import pmrs_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic evGo = 1'b0, evSec = 1'b0, sde = 1'b0, mReq = 1'b0, bme = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [3:0] hprot = 4'h0;
  logic [31:0] hwdata = 32'h00000000;
  logic [7:0] evIdx = 8'h00;
  logic [4:0] sErr = 5'h00;
  logic [2:0] mErr = 3'h0;
  wire logic hrdy, hresp, irqN, mSnp, mFwd;
  wire logic [31:0] hrdata;
  wire logic [1:0] aResp;
  wire logic [EV_W-1:0] evVec, evSecV;
  int numErrors = 0, nCompared = 0;
  always #12.5 mclk = ~mclk;
  pmrs_event_src u_pmrs_event_src (.go(evGo), .idx(evIdx), .sec(evSec),
    .pulses(evVec), .secure(evSecV));
  pmrs_perf_monitor u_pmrs_perf_monitor (.mclk(mclk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hprot(hprot), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .accessResp(aResp),
    .event_pulse_vector(evVec), .eventSecure(evSecV),
    .secure_debug_enable(sde), .slvImpErr(sErr), .mstImpErr(mErr),
    .error_irq_n(irqN), .maintReq(mReq), .broadcast_maint_en(bme),
    .maintSnoop(mSnp), .maintForward(mFwd));
  task automatic test_done();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitRdy();
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (hrdy !== 1'b1 && i < 50);
    if (hrdy !== 1'b1) begin
      numErrors++;
      test_done();
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic ns,
    input logic [31:0] wd, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    haddr <= a;
    hwrite <= w;
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hprot <= {2'h0, ns, 1'b0};
    waitRdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    waitRdy();
    d = hrdata;
    r = aResp;
    chk({31'h0, hresp}, 32'h00000000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
    input logic ns, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    xfer(a, 1'b1, ns, v, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rdc(input logic [11:0] a, input logic ns,
    input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    xfer(a, 1'b0, ns, 32'h00000000, d, r);
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic fire(input logic [7:0] i, input logic s, input int n);
    repeat (n) begin
      @(posedge mclk);
      evIdx <= i;
      evSec <= s;
      evGo <= 1'b1;
      @(posedge mclk);
      evGo <= 1'b0;
    end
  endtask
  function automatic logic [11:0] ca(input int n, input logic [3:0] s);
    return OFF_CNT_BASE + (12'(n) << 4) + {8'h00, s};
  endfunction
  initial begin
    repeat (20000) @(posedge mclk);
    numErrors++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(OFF_CTRL, 1'b1, 32'h00000000, RESP_OKAY);
    wr(ca(0, SUB_SEL), 32'h00000063, 1'b1, RESP_OKAY);
    wr(ca(1, SUB_SEL), 32'h0000006A, 1'b1, RESP_OKAY);
    wr(ca(0, SUB_CTL), 32'h00000001, 1'b0, RESP_OKAY);
    wr(OFF_CTRL, 32'h00000007, 1'b0, RESP_OKAY);
    fire(8'h63, 1'b0, 3);
    fire(8'h6A, 1'b0, 2);
    fire(8'h63, 1'b1, 1);
    sde <= 1'b1;
    fire(8'h63, 1'b1, 1);
    rdc(ca(0, SUB_CNT), 1'b0, 32'h00000004, RESP_OKAY);
    rdc(ca(1, SUB_CNT), 1'b0, 32'h00000000, RESP_OKAY);
    sde <= 1'b0;
    wr(OFF_CTRL, 32'h00000000, 1'b0, RESP_OKAY);
    wr(OFF_CTRL, 32'h00000006, 1'b0, RESP_OKAY);
    fire(8'h63, 1'b0, 1);
    rdc(ca(0, SUB_CNT), 1'b0, 32'h00000000, RESP_OKAY);
    wr(OFF_CYC, 32'h00000000, 1'b0, RESP_OKAY);
    wr(OFF_CTRL, 32'h00000001, 1'b0, RESP_OKAY);
    wr(OFF_CTRL, 32'h00000000, 1'b0, RESP_OKAY);
    rdc(OFF_CYC, 1'b0, 32'h00000003, RESP_OKAY);
    rdc(OFF_CYC, 1'b0, 32'h00000003, RESP_OKAY);
    $display("test counting done");
    wr(OFF_CYC, 32'hFFFFFFFF, 1'b0, RESP_OKAY);
    wr(ca(0, SUB_CNT), 32'hFFFFFFFF, 1'b0, RESP_OKAY);
    wr(OFF_CTRL, 32'h00000001, 1'b0, RESP_OKAY);
    fire(8'h63, 1'b0, 1);
    wr(OFF_CTRL, 32'h00000000, 1'b0, RESP_OKAY);
    rdc(ca(0, SUB_CNT), 1'b0, 32'h00000000, RESP_OKAY);
    rdc(OFF_OVF, 1'b0, 32'h00000011, RESP_OKAY);
    wr(OFF_OVF, 32'h00000011, 1'b0, RESP_OKAY);
    rdc(OFF_OVF, 1'b0, 32'h00000000, RESP_OKAY);
    $display("test overflow done");
    rdc(OFF_SNPCTL, 1'b1, 32'h00000000, RESP_DECERR);
    wr(OFF_SNPCTL, 32'h00000001, 1'b1, RESP_DECERR);
    rdc(OFF_SNPCTL, 1'b0, 32'h00000000, RESP_OKAY);
    wr(OFF_SECACC, 32'h00000001, 1'b1, RESP_DECERR);
    wr(OFF_SECACC, 32'h00000001, 1'b0, RESP_OKAY);
    wr(OFF_SNPCTL, 32'h00000001, 1'b1, RESP_OKAY);
    rdc(OFF_CTLOVR, 1'b1, 32'h00000000, RESP_DECERR);
    chk({31'h0, irqN}, 32'h00000001);
    $display("test security done");
    for (int b = 0; b < 2; b++) begin
      @(posedge mclk);
      bme <= 1'(b);
      mReq <= 1'b1;
      @(posedge mclk);
      mReq <= 1'b0;
      #1 chk({30'h0, mSnp, mFwd}, {30'h0, 1'b1, 1'(b)});
    end
    @(posedge mclk);
    sErr <= 5'h04;
    @(posedge mclk);
    sErr <= 5'h00;
    #1 chk({31'h0, irqN}, 32'h00000000);
    @(posedge mclk);
    mErr <= 3'h2;
    @(posedge mclk);
    mErr <= 3'h0;
    rdc(OFF_IMPERR, 1'b0, 32'h00000204, RESP_OKAY);
    wr(OFF_IMPERR, 32'h00000204, 1'b0, RESP_OKAY);
    #1 chk({31'h0, irqN}, 32'h00000001);
    $display("test errors done");
    test_done();
  end
endmodule
